/* rtl/dfc_dac_ctrl.sv */
// Purpose: control register, data byte holding and update latch for one 12-bit DAC
// Assumes: timer overflow inputs are one-cycle pulses on core_clk
// Notes: all outputs registered; read data is valid the cycle after sfr_rd
`timescale 1ns/10ps

// Functional notes
// R1: Enable bit powers converter and drives output
// R2: Control bits six, five read zero
// R3: Mode 00 latches on high byte write
// R4: Mode 01 latches on timer 3 overflow
// R5: Mode 10 latches on timer 4 overflow
// R6: Mode 11 latches on timer 2 overflow
// R7: Code 000: high[3:0], low[7:0]
// R8: Code 001: high[4:0], low[7:1]
// R9: Code 010: high[5:0], low[7:2]
// R10: Code 011: high[6:0], low[7:3]
// R11: Other codes: high[7:0], low[7:4]
// R12: Control at 0xD4 on page zero
// R13: Low write held until high write
// R14: Timer modes hold both bytes until overflow
// R15: Converter code is twelve bits wide
// R16: Only selected timer pulse causes transfer
// R17: Reset clears control register entirely
module dfc_dac_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timer2_ovf,
  input wire logic timer3_ovf,
  input wire logic timer4_ovf,
  output logic [11:0] dac_code,
  output logic dac_power_on,
  output logic dac_out_enable
);
  // Whole package: addresses, field positions, encodings
  import dfc_pkg::*;

  // Stored registers
  logic [7:0] ctrl; // Control register
  logic [7:0] data_high; // Held high data byte
  logic [7:0] data_low; // Held low data byte
  // Next values
  logic [7:0] next_ctrl;
  logic [7:0] next_high;
  logic [7:0] next_low;
  logic [7:0] next_rdata;
  logic [11:0] next_code;
  logic next_power_on;
  // Decode
  logic page_hit; // Page select matches
  logic sel_ctrl;
  logic sel_high;
  logic sel_low;
  logic wr_high; // High byte write strobe
  logic upd_evt; // Latch transfer this cycle
  dfc_upd_e upd_src; // Current update source
  logic [2:0] fmt; // Current justification code
  logic [11:0] packed_code; // Justified word from next bytes

  assign upd_src = dfc_upd_e'(ctrl[DFC_MODE_LSB +: 2]);
  assign fmt = ctrl[DFC_FMT_LSB +: 3];

  // Assemble the 12-bit word from the two bytes
  // Codes 100 to 111 all fall into the wide-high default
  function automatic logic [11:0] dfc_justify(
    input logic [2:0] f,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic [11:0] w;
    w = 12'h000;
    case (f)
      DFC_FMT_H4: begin
        w = {hi[3:0], lo}; // R7
      end
      DFC_FMT_H5: begin
        w = {hi[4:0], lo[7:1]}; // R8
      end
      DFC_FMT_H6: begin
        w = {hi[5:0], lo[7:2]}; // R9
      end
      DFC_FMT_H7: begin
        w = {hi[6:0], lo[7:3]}; // R10
      end
      default: begin
        w = {hi, lo[7:4]}; // R11
      end
    endcase
    return w;
  endfunction : dfc_justify

  // Address decode; every register lives on one page
  // Data byte addresses are local picks beside the fixed control address
  always_comb begin
    page_hit = (sfr_page == DFC_PAGE); // R12
    sel_ctrl = page_hit && (sfr_addr == DFC_CTRL_ADDR); // R12
    sel_high = page_hit && (sfr_addr == DFC_HIGH_ADDR);
    sel_low = page_hit && (sfr_addr == DFC_LOW_ADDR);
    wr_high = sfr_wr && sel_high;
  end

  // Register writes; unused control bits are masked off on the way in
  always_comb begin
    next_ctrl = ctrl;
    next_high = data_high;
    next_low = data_low;
    if (sfr_wr && sel_ctrl) begin
      next_ctrl = sfr_wdata & DFC_CTRL_WMASK; // R2
    end
    if (wr_high) begin
      next_high = sfr_wdata;
    end
    if (sfr_wr && sel_low) begin
      next_low = sfr_wdata; // R13 R14
    end
  end

  // Update trigger; only the timer chosen by the mode field counts
  // Non-selected timer pulses fall through and are ignored
  always_comb begin
    case (upd_src)
      DFC_UPD_WRITE: begin
        upd_evt = wr_high; // R3 R13
      end
      DFC_UPD_TMR3: begin
        upd_evt = timer3_ovf; // R4 R16
      end
      DFC_UPD_TMR4: begin
        upd_evt = timer4_ovf; // R5 R16
      end
      DFC_UPD_TMR2: begin
        upd_evt = timer2_ovf; // R6 R16
      end
      default: begin
        upd_evt = 1'b0;
      end
    endcase
  end

  // Latch next value; uses the bytes as they stand after this cycle's write
  // so a write coinciding with an overflow is not lost
  always_comb begin
    packed_code = dfc_justify(fmt, next_high, next_low); // R15
    next_code = dac_code;
    if (upd_evt) begin
      next_code = packed_code; // R14
    end
    next_power_on = next_ctrl[DFC_EN_BIT]; // R1
  end

  // Read mux; unmapped addresses read zero
  // Registered read keeps bus timing independent of decode depth
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_rd) begin
      if (sel_ctrl) begin
        next_rdata = ctrl & DFC_CTRL_WMASK; // R2
      end else if (sel_high) begin
        next_rdata = data_high;
      end else if (sel_low) begin
        next_rdata = data_low;
      end else begin
        next_rdata = 8'h00;
      end
    end
  end

  // State registers; async reset leaves the channel off in write mode
  // Data bytes cleared too, so a first timer update is deterministic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= DFC_CTRL_RESET; // R17
      data_high <= DFC_DATA_RESET;
      data_low <= DFC_DATA_RESET;
      dac_code <= DFC_CODE_RESET;
      sfr_rdata <= DFC_DATA_RESET;
      dac_power_on <= 1'b0;
      dac_out_enable <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      data_high <= next_high;
      data_low <= next_low;
      dac_code <= next_code;
      sfr_rdata <= next_rdata;
      // Both follow enable; output stays undriven while powered down
      dac_power_on <= next_power_on; // R1
      dac_out_enable <= next_power_on; // R1
    end
  end

  // Checks; all sampled on the system clock and quiet while reset is low
  // Layout checks compare against the held bytes one cycle later,
  // where the latch and the byte registers have both settled
  default clocking dfc_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Enable outputs follow the written bit at the same edge
  a_enable_follow: assert property ( // R1
    (sfr_wr && sel_ctrl) |=> (dac_out_enable == $past(sfr_wdata[DFC_EN_BIT]))
      && (dac_power_on == dac_out_enable))
    else $error("enable outputs do not follow control write");

  // Bits six and five are masked on write and on read
  a_unused_zero: assert property ( // R2
    (sfr_rd && sel_ctrl) |=> (sfr_rdata[6:5] == 2'h0))
    else $error("unused control bits read nonzero");

  // Each update source transfers the justified held word
  a_write_update: assert property ( // R3
    (wr_high && upd_src == DFC_UPD_WRITE)
      |=> dac_code == dfc_justify($past(fmt), data_high, data_low))
    else $error("high byte write did not update code");

  a_tmr3_update: assert property ( // R4
    (timer3_ovf && upd_src == DFC_UPD_TMR3)
      |=> dac_code == dfc_justify($past(fmt), data_high, data_low))
    else $error("timer 3 overflow did not update code");

  a_tmr4_update: assert property ( // R5
    (timer4_ovf && upd_src == DFC_UPD_TMR4)
      |=> dac_code == dfc_justify($past(fmt), data_high, data_low))
    else $error("timer 4 overflow did not update code");

  a_tmr2_update: assert property ( // R6
    (timer2_ovf && upd_src == DFC_UPD_TMR2)
      |=> dac_code == dfc_justify($past(fmt), data_high, data_low))
    else $error("timer 2 overflow did not update code");

  // Layout spot checks, independent of the shared helper
  a_fmt_nibble: assert property ( // R7
    (upd_evt && fmt == 3'h0) |=> (dac_code[11:8] == data_high[3:0])
      && (dac_code[7:0] == data_low))
    else $error("format 000 layout wrong");

  a_fmt_wide: assert property ( // R11
    (upd_evt && fmt[2]) |=> (dac_code == {data_high, data_low[7:4]}))
    else $error("wide-high layout wrong");

  // A lone low byte write must not reach the latch
  a_low_held: assert property ( // R13
    (sfr_wr && sel_low && upd_src == DFC_UPD_WRITE && !wr_high)
      |=> $stable(dac_code))
    else $error("low byte write changed code");

  // Timer modes hold the latch between selected overflows
  a_timer_hold: assert property ( // R14
    (upd_src != DFC_UPD_WRITE && !upd_evt) |=> $stable(dac_code))
    else $error("code changed without selected overflow");

  // Accesses aimed at another page leave control alone
  a_page_guard: assert property ( // R12
    (sfr_wr && sfr_page != DFC_PAGE) |=> $stable(ctrl))
    else $error("control changed from wrong page");

  // Narrower-high layouts; a slip here shifts the whole output scale
  a_fmt_five: assert property ( // R8
    (upd_evt && fmt == 3'h1) |=> (dac_code[11:7] == data_high[4:0])
      && (dac_code[6:0] == data_low[7:1]))
    else $error("format 001 layout wrong");

  a_fmt_six: assert property ( // R9
    (upd_evt && fmt == 3'h2) |=> (dac_code[11:6] == data_high[5:0])
      && (dac_code[5:0] == data_low[7:2]))
    else $error("format 010 layout wrong");

  a_fmt_seven: assert property ( // R10
    (upd_evt && fmt == 3'h3) |=> (dac_code[11:5] == data_high[6:0])
      && (dac_code[4:0] == data_low[7:3]))
    else $error("format 011 layout wrong");

  // In write mode the timers must never move the latch
  a_write_only: assert property ( // R16
    (upd_src == DFC_UPD_WRITE && !wr_high) |=> $stable(dac_code))
    else $error("code changed in write mode without high write");

  // Enable outputs only move on a control write
  a_enable_hold: assert property ( // R1
    !(sfr_wr && sel_ctrl) |=> $stable(dac_power_on) && $stable(dac_out_enable))
    else $error("enable outputs changed without control write");

  // Unmapped or foreign-page reads return zero rather than stale data
  a_unmapped_zero: assert property ( // R12
    (sfr_rd && !(sel_ctrl || sel_high || sel_low)) |=> (sfr_rdata == 8'h00))
    else $error("unmapped read returned nonzero");

  // First edge after reset release still shows the cleared state
  a_reset_clear: assert property ( // R17
    $rose(rst_n) |-> (ctrl == DFC_CTRL_RESET) && (dac_code == DFC_CODE_RESET)
      && !dac_power_on && !dac_out_enable)
    else $error("state not cleared after reset");

  // Scenarios the bench is expected to reach
  c_write_mode: cover property (wr_high && upd_src == DFC_UPD_WRITE ##1 dac_out_enable);
  c_timer_mode: cover property (upd_src == DFC_UPD_TMR2 && timer2_ovf);
  c_wrong_timer: cover property (upd_src == DFC_UPD_TMR3 && timer4_ovf && !timer3_ovf);
  c_wide_fmt: cover property (upd_evt && fmt == 3'h7);
  c_foreign_page: cover property (sfr_rd && !page_hit);
endmodule : dfc_dac_ctrl

/* rtl/dfc_pkg.sv */
// Purpose: shared constants for the DAC update and format control block
// Assumes: 8-bit special-function register bus with a page select
// Notes: data byte addresses are local choices, control address is fixed
package dfc_pkg;
  // Register page and addresses
  localparam logic [7:0] DFC_PAGE = 8'h00;
  localparam logic [7:0] DFC_CTRL_ADDR = 8'hD4;
  localparam logic [7:0] DFC_LOW_ADDR = 8'hD2;
  localparam logic [7:0] DFC_HIGH_ADDR = 8'hD3;
  // Control field positions
  localparam int DFC_EN_BIT = 7;
  localparam int DFC_MODE_LSB = 3;
  localparam int DFC_FMT_LSB = 0;
  // Writable bits of control; bits 6..5 never stored
  localparam logic [7:0] DFC_CTRL_WMASK = 8'h9F;
  // Values after reset
  localparam logic [7:0] DFC_CTRL_RESET = 8'h00;
  localparam logic [7:0] DFC_DATA_RESET = 8'h00;
  localparam logic [11:0] DFC_CODE_RESET = 12'h000;
  // Update source encodings
  typedef enum logic [1:0] {
    DFC_UPD_WRITE = 2'h0,
    DFC_UPD_TMR3 = 2'h1,
    DFC_UPD_TMR4 = 2'h2,
    DFC_UPD_TMR2 = 2'h3
  } dfc_upd_e;
  // Justification codes; any code with bit 2 set uses the wide-high layout
  typedef enum logic [2:0] {
    DFC_FMT_H4 = 3'h0,
    DFC_FMT_H5 = 3'h1,
    DFC_FMT_H6 = 3'h2,
    DFC_FMT_H7 = 3'h3,
    DFC_FMT_H8 = 3'h4
  } dfc_fmt_e;
endpackage : dfc_pkg

/* verif/dfc_core_model.sv */
// Purpose: core-side model driving register bus and timer overflows
// Assumes: strobes launched at the falling edge, one cycle each
// Notes: pg lets a test aim an access at a foreign page
`timescale 1ns/10ps
module dfc_core_model (
  input wire logic core_clk,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_page,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  output logic [4:2] tmr_ovf
);
  logic [7:0] pg; // Page used by accesses
  // Idle bus at time zero
  initial begin
    pg = 8'h00;
    sfr_page = 8'h00;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    tmr_ovf = 3'h0;
  end
  // One write, page set with the address
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_page = pg;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    sfr_wdata = ~d; // Stale data never left on the bus
  endtask : wr
  // One read, data taken after the strobe edge landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_page = pg;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
  // One-cycle overflow pulse from timer n
  task automatic tick(input int n);
    @(negedge core_clk);
    tmr_ovf[n] = 1'b1;
    @(negedge core_clk);
    tmr_ovf = 3'h0;
  endtask : tick
endmodule : dfc_core_model

/* verif/tb_dfc_dac_ctrl.sv */
// Purpose: self-checking bench for the DAC update and format control
// Assumes: core model owns register bus and timer pulses
// Notes: expected codes come from the layout function below
`timescale 1ns/10ps
module tb_dfc_dac_ctrl;
  import dfc_pkg::*;
  logic core_clk, rst_n, wr, rd, pwr, oe;
  logic [7:0] page, addr, wdata, rdata, r;
  logic [4:2] ovf;
  logic [11:0] code, e;
  int n_mismatch = 0;
  int checks_done = 0;
  int t;
  dfc_dac_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .sfr_page(page), .sfr_addr(addr),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .timer2_ovf(ovf[2]),
    .timer3_ovf(ovf[3]), .timer4_ovf(ovf[4]), .dac_code(code), .dac_power_on(pwr),
    .dac_out_enable(oe));
  dfc_core_model core (.core_clk(core_clk), .sfr_rdata(rdata), .sfr_page(page),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .tmr_ovf(ovf));
  // 5 ns clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Counts, verdict, end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // Compare and report
  task automatic chk(input string nm, input logic [11:0] x, input logic [11:0] g);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // Expected code for a justification setting
  function automatic logic [11:0] lay(input logic [2:0] f, input logic [7:0] h, l);
    case (f)
      3'h0: return {h[3:0], l};
      3'h1: return {h[4:0], l[7:1]};
      3'h2: return {h[5:0], l[7:2]};
      3'h3: return {h[6:0], l[7:3]};
      default: return {h, l[7:4]};
    endcase
  endfunction : lay
  // Watchdog; the run needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    chk("code", DFC_CODE_RESET, code);
    core.rd(DFC_CTRL_ADDR, r);
    chk("ctrl", 12'(DFC_CTRL_RESET), 12'(r));
    chk("power", 12'h000, 12'(pwr));
    core.wr(DFC_CTRL_ADDR, 8'hFF);
    core.rd(DFC_CTRL_ADDR, r);
    chk("ctrl", 12'h09F, 12'(r));
    chk("oe", 12'h001, 12'(oe));
    core.pg = 8'h01;
    core.wr(DFC_CTRL_ADDR, 8'h00);
    core.pg = 8'h00;
    chk("power", 12'h001, 12'(pwr));
    e = 12'h000;
    // Every layout, write-triggered; timers must not update
    for (int f = 0; f < 8; f++) begin
      core.wr(DFC_CTRL_ADDR, 8'(f));
      chk("oe", 12'h000, 12'(oe));
      core.wr(DFC_LOW_ADDR, 8'hC3 ^ 8'(f));
      chk("held", e, code);
      core.wr(DFC_HIGH_ADDR, 8'h5A + 8'(f));
      e = lay(3'(f), 8'h5A + 8'(f), 8'hC3 ^ 8'(f));
      core.tick(2);
      core.tick(3);
      core.tick(4);
      chk("code", e, code);
    end
    // Both ends of the code range, channel enabled, wide layout
    core.wr(DFC_CTRL_ADDR, 8'h84);
    chk("oe", 12'h001, 12'(oe));
    for (int i = 0; i < 2; i++) begin
      core.wr(DFC_LOW_ADDR, i ? 8'h00 : 8'hFF);
      core.wr(DFC_HIGH_ADDR, i ? 8'h00 : 8'hFF);
      chk("span", i ? 12'h000 : 12'hFFF, code);
    end
    e = 12'h000;
    // Timer modes: wrong timers ignored, selected one transfers
    for (int m = 1; m < 4; m++) begin
      t = (m == 1) ? 3 : (m == 2) ? 4 : 2;
      core.wr(DFC_CTRL_ADDR, 8'h82 | 8'(m << 3));
      chk("power", 12'h001, 12'(pwr));
      core.wr(DFC_LOW_ADDR, 8'h30 + 8'(m));
      core.wr(DFC_HIGH_ADDR, 8'h0F - 8'(m));
      chk("held", e, code);
      for (int k = 2; k < 5; k++) begin
        if (k != t) begin
          core.tick(k);
        end
      end
      chk("held", e, code);
      core.tick(t);
      e = lay(3'h2, 8'h0F - 8'(m), 8'h30 + 8'(m));
      chk("code", e, code);
    end
    // Held byte reads back; foreign page reads zero
    core.rd(DFC_HIGH_ADDR, r);
    chk("high", 12'h00C, 12'(r));
    core.pg = 8'h01;
    core.rd(DFC_CTRL_ADDR, r);
    core.pg = 8'h00;
    chk("page", 12'h000, 12'(r));
    // Second reset in mid-run
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    chk("code", DFC_CODE_RESET, code);
    chk("power", 12'h000, 12'(pwr));
    core.rd(DFC_CTRL_ADDR, r);
    chk("ctrl", 12'(DFC_CTRL_RESET), 12'(r));
    core.wr(DFC_LOW_ADDR, 8'hA5);
    core.wr(DFC_HIGH_ADDR, 8'h07);
    chk("code", lay(3'h0, 8'h07, 8'hA5), code);
    test_done();
  end
endmodule : tb_dfc_dac_ctrl
